// ===== inc/sssh_pkg.sv
// Notes on behaviour
// - Refuse serial accesses while supply is low
// - Select backup SRAM supply during power fail
// - One shared data line, clocked by host
// - Interrupt high while flag and enable set
// - Interrupt works on main or backup power
// - Low byte select when both enables low
// - High byte select when both enables low
// - Missing strobe before timeout forces reset
// - Reset low on supply, watchdog, powerup, button
// - Debounced button gives at least 250 ms reset
// - Serial, strobe and button inputs disabled until powerup delay elapses
// - Supply low drives reset low immediately
// - Hold reset 250 ms after supply returns
// - Each transfer opens with a command byte
// - Bits 0-6 address, bit 7 write when set
// - Supervisor timing from 32.768 kHz crystal base; crystal loss timed in sys_clk cycles
package sssh_pkg;
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned XTAL_HZ = 32_768;
  localparam int unsigned POWERUP_HOLD_MS = 250;
  localparam int unsigned BUTTON_PULSE_MS = 250;
  localparam int unsigned POWERUP_HOLD_TICKS = (XTAL_HZ * POWERUP_HOLD_MS) / 1000;
  localparam int unsigned BUTTON_PULSE_TICKS = (XTAL_HZ * BUTTON_PULSE_MS + 999) / 1000;
  localparam int unsigned DEBOUNCE_TICKS = 16'h0100;
  localparam int unsigned WATCHDOG_TICKS = 32'h0000_8000;
  localparam int unsigned CMD_DIR_BIT = 7;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned XTAL_LOSS_CYCLES = (SYS_CLK_HZ / XTAL_HZ) * 4;
  localparam logic [8:0] SYNC_IDLE = 9'h030;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
  } sssh_cmd_s;

  typedef enum logic [1:0] {
    SSSH_IDLE = 2'b00,
    SSSH_CMD = 2'b01,
    SSSH_DATA = 2'b11,
    SSSH_DONE = 2'b10
  } sssh_state_e;
endpackage : sssh_pkg

// ===== rtl/sssh_top.sv
`timescale 1ns/10ps
module sssh_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sssh_fifo depth must be a power of two");
    if (WIDTH < 1) $error("sssh_fifo width must be at least one");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  // Extra pointer bit tells full from empty
  logic [AW:0] wp_r, wp_nxt;
  logic [AW:0] rp_r, rp_nxt;
  logic full, empty;
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = wp_r == rp_r;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_r[AW-1:0]];
  always_comb
  begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (in_valid && !full) wp_nxt = wp_r + 1'b1;
    if (out_ready && !empty) rp_nxt = rp_r + 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (in_valid && !full) mem[wp_r[AW-1:0]] <= in_data;
    if (reset)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
endmodule : sssh_fifo

////////////////////////////////////////////////////////////////////////
module sssh_top import sssh_pkg::*; #(
  parameter int unsigned WDOG_TICKS = WATCHDOG_TICKS,
  parameter int unsigned PU_TICKS = POWERUP_HOLD_TICKS,
  parameter int unsigned BTN_TICKS = BUTTON_PULSE_TICKS,
  parameter int unsigned DEB_TICKS = DEBOUNCE_TICKS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic xtal_in,
  input wire logic supply_low,
  input wire logic power_fail,
  output logic backup_select,
  input wire logic watchdog_strobe_n,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic alarm_flag,
  input wire logic alarm_enable,
  output logic interrupt,
  input wire logic ram_enable_in_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  output logic ram_low_select_n,
  output logic ram_high_select_n,
  input wire logic serial_clk,
  input wire logic serial_cs,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  input wire logic [7:0] read_data
);
  initial
  begin
    if (WDOG_TICKS < 2 || PU_TICKS < 2 || BTN_TICKS < 2 || DEB_TICKS < 2) $error("sssh_top counts too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers
  localparam int unsigned NS = 9;
  logic [NS-1:0] raw, s1_r, s2_r;
  assign raw = {xtal_in, supply_low, power_fail, watchdog_strobe_n, reset_pin_in,
                serial_clk, serial_cs, serial_data_in, alarm_flag};
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  logic x_s, slow_s, pf_s, st_s, rpin_s, sck_s, cs_s, sdi_s, alm_s;
  assign {x_s, slow_s, pf_s, st_s, rpin_s, sck_s, cs_s, sdi_s, alm_s} = s2_r;

  ////////////////////////////////////////////////////////////////////////
  // Crystal tick and supervisor timers
  logic x_d_r, tick;
  logic [31:0] pu_r, pu_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [31:0] btn_r, btn_nxt;
  logic [31:0] deb_r, deb_nxt;
  logic [15:0] xl_r, xl_nxt;
  logic st_d_r, strobe_fall, enabled, btn_low, xtal_lost;
  assign tick = x_s && !x_d_r;
  // No crystal edge for too long reloads the powerup hold
  assign xtal_lost = xl_r == 16'(XTAL_LOSS_CYCLES);
  assign strobe_fall = st_d_r && !st_s;
  assign enabled = pu_r == '0;
  // Own drive of the pin is not a button press
  assign btn_low = !rpin_s && !reset_pin_oe;
  always_comb
  begin
    pu_nxt = pu_r;
    wd_nxt = wd_r;
    btn_nxt = btn_r;
    deb_nxt = deb_r;
    xl_nxt = xl_r;
    if (tick) xl_nxt = '0;
    else if (!xtal_lost) xl_nxt = xl_r + 1'b1;
    if (slow_s || xtal_lost) pu_nxt = PU_TICKS;
    else if (tick && pu_r != '0) pu_nxt = pu_r - 1'b1;
    if (!enabled || strobe_fall || wd_r == '0) wd_nxt = WDOG_TICKS;
    else if (tick) wd_nxt = wd_r - 1'b1;
    if (!btn_low || !enabled) deb_nxt = '0;
    else if (tick && deb_r != DEB_TICKS) deb_nxt = deb_r + 1'b1;
    if (deb_r == DEB_TICKS && btn_r == '0) btn_nxt = BTN_TICKS;
    else if (tick && btn_r != '0) btn_nxt = btn_r - 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      x_d_r <= 1'b0;
      st_d_r <= 1'b1;
      pu_r <= PU_TICKS;
      wd_r <= WDOG_TICKS;
      btn_r <= '0;
      deb_r <= '0;
      xl_r <= '0;
    end
    else
    begin
      x_d_r <= x_s;
      st_d_r <= st_s;
      pu_r <= pu_nxt;
      wd_r <= wd_nxt;
      btn_r <= btn_nxt;
      deb_r <= deb_nxt;
      xl_r <= xl_nxt;
    end
  end

  // Open-drain reset pin: drive low or release
  logic rst_act;
  assign rst_act = slow_s || !enabled || wd_r == '0 || btn_r != '0;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = rst_act;
  assign backup_select = pf_s;
  assign interrupt = alm_s && alarm_enable;
  assign ram_low_select_n = !(!ram_enable_in_n && !low_byte_enable_n);
  assign ram_high_select_n = !(!ram_enable_in_n && !high_byte_enable_n);

  ////////////////////////////////////////////////////////////////////////
  // Serial link
  sssh_state_e st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [2:0] bc_r, bc_nxt;
  sssh_cmd_s cmd_r, cmd_nxt;
  logic sck_d_r, rise, fall;
  logic link_ok, push;
  logic oe_r, oe_nxt;
  logic [7:0] push_data;
  logic fifo_ready;
  assign rise = sck_s && !sck_d_r;
  assign fall = !sck_s && sck_d_r;
  assign link_ok = cs_s && enabled && !slow_s;
  always_comb
  begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bc_nxt = bc_r;
    cmd_nxt = cmd_r;
    tx_nxt = tx_r;
    oe_nxt = oe_r;
    push = 1'b0;
    push_data = sh_r;
    cmd_valid = 1'b0;
    if (!link_ok)
    begin
      st_nxt = SSSH_IDLE;
      oe_nxt = 1'b0;
      bc_nxt = '0;
    end
    else
    begin
      case (st_r)
        SSSH_IDLE:
        begin
          st_nxt = SSSH_CMD;
          bc_nxt = '0;
        end
        SSSH_CMD:
        begin
          if (rise)
          begin
            sh_nxt = {sdi_s, sh_r[7:1]};
            bc_nxt = bc_r + 1'b1;
            if (bc_r == 3'd7)
            begin
              cmd_nxt = sssh_cmd_s'({sdi_s, sh_r[7:1]});
              cmd_valid = 1'b1;
              st_nxt = SSSH_DATA;
              tx_nxt = read_data;
            end
          end
        end
        SSSH_DATA:
        begin
          oe_nxt = !cmd_r.write;
          if (rise && cmd_r.write)
          begin
            sh_nxt = {sdi_s, sh_r[7:1]};
            bc_nxt = bc_r + 1'b1;
            if (bc_r == 3'd7)
            begin
              push = 1'b1;
              push_data = {sdi_s, sh_r[7:1]};
              if (!fifo_ready) st_nxt = SSSH_DONE;
            end
          end
          else if (fall && !cmd_r.write && oe_r)
          begin
            tx_nxt = {1'b0, tx_r[7:1]};
          end
        end
        // Full FIFO: ignore rest until select drops
        SSSH_DONE: st_nxt = SSSH_DONE;
        default: st_nxt = SSSH_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_r <= SSSH_IDLE;
      sh_r <= '0;
      bc_r <= '0;
      cmd_r <= '0;
      tx_r <= '0;
      oe_r <= 1'b0;
      sck_d_r <= 1'b0;
      cmd_byte <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bc_r <= bc_nxt;
      cmd_r <= cmd_nxt;
      tx_r <= tx_nxt;
      oe_r <= oe_nxt;
      sck_d_r <= sck_s;
      if (cmd_valid) cmd_byte <= {cmd_nxt.write, cmd_nxt.addr};
    end
  end
  assign serial_data_out = tx_r[0];
  assign serial_data_oe = oe_r;

  sssh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
endmodule : sssh_top

// ===== tb/sssh_top_asserts.sv
`timescale 1ns/10ps
module sssh_top_asserts import sssh_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic supply_low,
  input wire logic power_fail,
  input wire logic backup_select,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic alarm_flag,
  input wire logic alarm_enable,
  input wire logic interrupt,
  input wire logic ram_enable_in_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic ram_low_select_n,
  input wire logic ram_high_select_n,
  input wire logic serial_cs,
  input wire logic serial_data_oe,
  input wire logic cmd_valid,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_low_select: assert property (ram_low_select_n == (ram_enable_in_n | low_byte_enable_n))
    else $error("low byte select wrong");
  a_high_select: assert property (ram_high_select_n == (ram_enable_in_n | high_byte_enable_n))
    else $error("high byte select wrong");
  a_supply_reset: assert property (supply_low |-> ##[0:4] reset_pin_oe)
    else $error("reset not driven on supply low");
  a_reset_drive: assert property (supply_low [*6] |-> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not driven low");
  a_refuse_access: assert property (supply_low [*4] |-> !cmd_valid)
    else $error("command taken while supply low");
  a_backup_on: assert property (power_fail [*3] |-> backup_select)
    else $error("backup not selected");
  a_main_return: assert property (!power_fail [*3] |-> !backup_select)
    else $error("main supply not reselected");
  a_int_enable: assert property (interrupt |-> alarm_enable)
    else $error("interrupt without enable");
  a_int_raise: assert property (alarm_flag [*3] ##0 alarm_enable |-> interrupt)
    else $error("interrupt missing");
  a_line_release: assert property (!serial_cs [*6] |-> !serial_data_oe)
    else $error("data line driven without select");
  a_cmd_pulse: assert property (cmd_valid |-> serial_cs ##1 !cmd_valid)
    else $error("command pulse wrong");
  c_cmd: cover property (cmd_valid);
  c_pop: cover property (rx_valid && rx_ready);
  c_int: cover property (interrupt && power_fail);
  c_read: cover property (serial_data_oe);
endmodule : sssh_top_asserts

bind sssh_top sssh_top_asserts chk (.*);

// ===== tb/sssh_host_model.sv
`timescale 1ns/10ps
module sssh_host_model (
  output logic sclk,
  output logic cs,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoe
);
  logic drv = 1'b0;
  logic val = 1'b0;
  initial {sclk, cs} = 2'b00;
  // Released line shows inverse of last level
  always_comb sdi = sdoe ? sdo : (drv ? val : ~val);
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      sclk = 1'b0;
      val = b[i];
      drv = 1'b1;
      #40 sclk = 1'b1;
      #40;
    end
  endtask : send
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [7:0] wd, output logic [7:0] rd);
    rd = 8'h00;
    cs = 1'b1;
    #40 send(cmd);
    for (int k = 0; k < n; k++) send(wd + 8'(k));
    drv = 1'b0;
    for (int i = 0; i < n * 0 + 8 && !cmd[7]; i++)
    begin
      #40 rd[i] = sdi;
      sclk = 1'b0;
      #40 sclk = 1'b1;
    end
    #40 sclk = 1'b0;
    cs = 1'b0;
    #80;
  endtask : xfer
endmodule : sssh_host_model

// ===== tb/sssh_top_tb.sv
`timescale 1ns/10ps
module sssh_top_tb import sssh_pkg::*;;
  logic sys_clk, reset, xtal_in, supply_low, power_fail, backup_select, watchdog_strobe_n, reset_pin_in;
  logic reset_pin_out, reset_pin_oe, alarm_flag, alarm_enable, interrupt, ram_enable_in_n, low_byte_enable_n;
  logic high_byte_enable_n, ram_low_select_n, ram_high_select_n, serial_clk, serial_cs, serial_data_in;
  logic serial_data_out, serial_data_oe, cmd_valid, rx_valid, rx_ready, btn, wd_on;
  logic [7:0] cmd_byte, rx_data, read_data, r;
  int fails = 0;
  int total_checks = 0;
  int n;
  logic xtal_on = 1'b1;
  sssh_top #(.WDOG_TICKS(50), .PU_TICKS(20), .BTN_TICKS(20), .DEB_TICKS(4)) dut (.*);
  sssh_host_model host (.sclk(serial_clk), .cs(serial_cs), .sdi(serial_data_in), .sdo(serial_data_out),
    .sdoe(serial_data_oe));
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : !btn;
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    xtal_in = 1'b0;
    forever #200 if (xtal_on) xtal_in = ~xtal_in;
  end
  always #2000 if (wd_on) watchdog_strobe_n = ~watchdog_strobe_n;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_oe(input logic lvl, output int c);
    c = 0;
    while (reset_pin_oe !== lvl && c < 20000)
    begin
      @(negedge sys_clk);
      c++;
    end
  endtask : wait_oe
  task automatic results;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  task automatic t_gates;
    for (int i = 0; i < 8; i++)
    begin
      {ram_enable_in_n, low_byte_enable_n, high_byte_enable_n} = 3'(i);
      @(negedge sys_clk);
      check({ram_low_select_n, ram_high_select_n}, {6'h00, 1'(i[2] | i[1]), 1'(i[2] | i[0])});
    end
  endtask : t_gates
  task automatic t_write;
    rx_ready = 1'b0;
    host.xfer(8'h85, 17, 8'h30, r);
    check(cmd_byte, 8'h85);
    @(negedge sys_clk);
    rx_ready = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      check({7'h00, rx_valid}, 8'h01);
      check(rx_data, 8'h30 + 8'(k));
      @(negedge sys_clk);
    end
    check(rx_valid, 1'b0);
  endtask : t_write
  task automatic t_read;
    read_data = 8'ha6;
    host.xfer(8'h12, 0, 8'h00, r);
    check(r, 8'ha6);
    check(cmd_byte, 8'h12);
  endtask : t_read
  task automatic t_supply;
    supply_low = 1'b1;
    repeat (10) @(negedge sys_clk);
    check(reset_pin_oe, 1'b1);
    host.xfer(8'h99, 1, 8'h55, r);
    check(cmd_byte, 8'h12);
    supply_low = 1'b0;
    wait_oe(1'b0, n);
    check(8'(n >= 760 && n <= 880), 8'h01);
  endtask : t_supply
  task automatic t_watchdog;
    wd_on = 1'b0;
    wait_oe(1'b1, n);
    check(8'(n >= 1500 && n <= 2100), 8'h01);
    wd_on = 1'b1;
    wait_oe(1'b0, n);
  endtask : t_watchdog
  task automatic t_button;
    btn = 1'b1;
    wait_oe(1'b1, n);
    check(8'(n <= 400), 8'h01);
    btn = 1'b0;
    wait_oe(1'b0, n);
    check(8'(n >= 760), 8'h01);
  endtask : t_button
  task automatic t_xtal;
    xtal_on = 1'b0;
    wait_oe(1'b1, n);
    check(8'(n >= 12100 && n <= 12300), 8'h01);
    xtal_on = 1'b1;
    wait_oe(1'b0, n);
    check(8'(n >= 780 && n <= 900), 8'h01);
  endtask : t_xtal
  task automatic t_irq;
    for (int i = 0; i < 8; i++)
    begin
      {power_fail, alarm_flag, alarm_enable} = 3'(i);
      repeat (4) @(negedge sys_clk);
      check({backup_select, interrupt}, {6'h00, 1'(i[2]), 1'(i[1] & i[0])});
    end
  endtask : t_irq
  initial
  begin
    {reset, btn, wd_on, watchdog_strobe_n, rx_ready} = 5'b10011;
    {supply_low, power_fail, alarm_flag, alarm_enable, read_data} = 12'h000;
    {ram_enable_in_n, low_byte_enable_n, high_byte_enable_n} = 3'b111;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    check(reset_pin_oe, 1'b1);
    wait_oe(1'b0, n);
    check(8'(n >= 750 && n <= 880), 8'h01);
    t_gates();
    t_write();
    t_read();
    t_supply();
    t_watchdog();
    t_button();
    t_xtal();
    t_irq();
    results();
  end
  initial
  begin
    #1_000_000;
    fails++;
    results();
  end
endmodule : sssh_top_tb
